//--- logic/phase_timer.sv
module phase_timer
    import sram_host_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst_b,
    phase_timer_if.timer tmr
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // ============================================================
    // Down counter: loaded as a phase starts, done in its last cycle
    // ============================================================
    always_comb begin
        cnt_d = cnt_q;
        if (tmr.load) begin
            cnt_d = tmr.count;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_d = cnt_q - CNT_ONE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Done is combinational so the owner can leave the phase on the same edge.
    assign tmr.done = (cnt_q == CNT_ONE);

endmodule

//--- logic/phase_timer_if.sv
interface phase_timer_if;
    import sram_host_pkg::*;

    logic             load;
    logic [CNT_W-1:0] count;
    logic             done;

    modport owner (output load, output count, input done);
    modport timer (input load, input count, output done);
endinterface

//--- logic/sram_host.sv
import sram_host_pkg::*;

// Functional notes
// - Array write happens only while select and strobe are both low.
// - The first of select or strobe rising ends the write.
// - Write data held stable from setup time before write end until it.
// - Address valid before write end; whole write cycle meets least length.
// - Byte selects held low long enough before write end.
// - Strobe write with drive low must stretch by float time plus setup.
// - Controller never drives the bus while the memory may drive it.
// - Write strobe stays high throughout every read.
// - Address is valid no later than select falling in a read.
module sram_host (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        grade_slow,
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]                  req_bytes,
    output logic                             req_ready_q,
    output logic                             rsp_valid_q,
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata_q,
    output logic [sram_host_pkg::ADDR_W-1:0] word_address_q,
    output logic                             chip_sel_n_q,
    output logic                             write_strobe_n_q,
    output logic                             out_drive_n_q,
    output logic                             upper_byte_sel_n_q,
    output logic                             lower_byte_sel_n_q,
    input  wire logic [sram_host_pkg::DATA_W-1:0] data_bus_sample,
    output logic [sram_host_pkg::DATA_W-1:0] data_bus_value_q,
    output logic                             data_bus_en_q
);
    import sram_host_pkg::*;

    // ============================================================
    // State and pin registers
    // ============================================================
    state_t              state_q, state_d;
    logic                slow_q, slow_d;
    logic                ready_d, rsp_valid_d;
    logic [DATA_W-1:0]   rdata_d, wdata_d;
    logic [ADDR_W-1:0]   addr_d;
    logic                cs_n_d, we_n_d, oe_n_d, ub_n_d, lb_n_d, den_d;

    phase_timer_if tmr ();

    phase_timer u_timer (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tmr   (tmr)
    );

    // Decode of the states in which the memory is selected.
    function automatic logic selected(input state_t s);
        return (s == ST_WR_SETUP) || (s == ST_WR_PULSE) || (s == ST_RD_WAIT);
    endfunction

    // Decode of the states in which our data drivers are on.
    function automatic logic driving(input state_t s);
        return (s == ST_WR_PULSE) || (s == ST_WR_END);
    endfunction

    // ============================================================
    // Sequencer next state
    // ============================================================
    // A write goes setup, strobe pulse, end; a read goes wait, end. The
    // sequencer always passes through idle after a write so our drivers are
    // off for a cycle before output drive can fall again.
    always_comb begin
        state_d     = state_q;
        slow_d      = slow_q;
        addr_d      = word_address_q;
        wdata_d     = data_bus_value_q;
        rdata_d     = rsp_rdata_q;
        ub_n_d      = upper_byte_sel_n_q;
        lb_n_d      = lower_byte_sel_n_q;
        rsp_valid_d = 1'b0;
        tmr.load    = 1'b0;
        tmr.count   = CNT_ZERO;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && req_ready_q) begin
                    slow_d = grade_slow;
                    addr_d = req_addr;
                    ub_n_d = !req_bytes[1];
                    lb_n_d = !req_bytes[0];
                    if (req_write) begin
                        wdata_d = req_wdata;
                        state_d = ST_WR_SETUP;
                    end else begin
                        tmr.load  = 1'b1;
                        tmr.count = grade_slow ? RD_WAIT_SLOW_CNT : RD_WAIT_FAST_CNT;
                        state_d   = ST_RD_WAIT;
                    end
                end
            end
            ST_WR_SETUP: begin
                tmr.load  = 1'b1;
                tmr.count = slow_q ? WR_PULSE_SLOW_CNT : WR_PULSE_FAST_CNT;
                state_d   = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                if (tmr.done) begin
                    state_d = ST_WR_END;
                end
            end
            ST_WR_END: begin
                state_d = ST_IDLE;
            end
            ST_RD_WAIT: begin
                if (tmr.done) begin
                    rdata_d     = data_bus_sample;
                    rsp_valid_d = 1'b1;
                    state_d     = ST_RD_END;
                end
            end
            ST_RD_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // Pin levels follow the next state so every pin is a flip-flop
    // ============================================================
    // Select and strobe rise on the same edge at write end, so the write
    // is closed by both at once and the memory stays floating afterwards.
    always_comb begin
        cs_n_d  = !selected(state_d);
        we_n_d  = (state_d != ST_WR_PULSE);
        oe_n_d  = (state_d != ST_RD_WAIT);
        den_d   = driving(state_d);
        ready_d = (state_d == ST_IDLE);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q            <= ST_IDLE;
            slow_q             <= 1'b0;
            req_ready_q        <= 1'b0;
            rsp_valid_q        <= 1'b0;
            rsp_rdata_q        <= '0;
            word_address_q     <= '0;
            chip_sel_n_q       <= 1'b1;
            write_strobe_n_q   <= 1'b1;
            out_drive_n_q      <= 1'b1;
            upper_byte_sel_n_q <= 1'b1;
            lower_byte_sel_n_q <= 1'b1;
            data_bus_value_q   <= '0;
            data_bus_en_q      <= 1'b0;
        end else begin
            state_q            <= state_d;
            slow_q             <= slow_d;
            req_ready_q        <= ready_d;
            rsp_valid_q        <= rsp_valid_d;
            rsp_rdata_q        <= rdata_d;
            word_address_q     <= addr_d;
            chip_sel_n_q       <= cs_n_d;
            write_strobe_n_q   <= we_n_d;
            out_drive_n_q      <= oe_n_d;
            upper_byte_sel_n_q <= ub_n_d;
            lower_byte_sel_n_q <= lb_n_d;
            data_bus_value_q   <= wdata_d;
            data_bus_en_q      <= den_d;
        end
    end

    // ============================================================
    // Checks on the pin sequence
    // ============================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence strobe_falls;
        $fell(write_strobe_n_q);
    endsequence

    sequence read_starts;
        $fell(chip_sel_n_q) && write_strobe_n_q && !out_drive_n_q;
    endsequence

    write_window_a: assert property (!write_strobe_n_q |-> !chip_sel_n_q)
        else $error("strobe low while deselected");

    write_end_a: assert property ($rose(write_strobe_n_q) |-> $rose(chip_sel_n_q))
        else $error("write not closed by select and strobe together");

    // The slow grade keeps the strobe low one cycle longer, so only the common part is checked here.
    data_setup_a: assert property (strobe_falls |-> data_bus_en_q throughout
        (!write_strobe_n_q [*2] ##1 $stable(data_bus_value_q)))
        else $error("write data not held through the strobe pulse");

    data_hold_a: assert property ($rose(write_strobe_n_q) |->
        data_bus_en_q && $stable(data_bus_value_q))
        else $error("write data not held up to write end");

    pulse_fast_a: assert property (strobe_falls ##0 !slow_q |->
        !write_strobe_n_q [*2] ##1 write_strobe_n_q)
        else $error("fast grade strobe pulse not two cycles");

    pulse_slow_a: assert property (strobe_falls ##0 slow_q |->
        !write_strobe_n_q [*3] ##1 write_strobe_n_q)
        else $error("slow grade strobe pulse not three cycles");

    no_contention_a: assert property (data_bus_en_q |-> out_drive_n_q && $past(out_drive_n_q))
        else $error("bus driven while memory output may be on");

    read_strobe_a: assert property (read_starts |-> write_strobe_n_q [*3])
        else $error("strobe fell during a read");

    address_hold_a: assert property (!chip_sel_n_q && !$past(chip_sel_n_q) |->
        $stable(word_address_q) && $stable(upper_byte_sel_n_q) && $stable(lower_byte_sel_n_q))
        else $error("address or byte select moved while selected");

    read_length_a: assert property (read_starts |-> !rsp_valid_q [*3] ##1 rsp_valid_q)
        else $error("read data sampled at the wrong cycle");

endmodule

//--- logic/sram_host_pkg.sv
package sram_host_pkg;

    // ============================================================
    // Widths of the memory port and of the phase counter
    // ============================================================
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CNT_W  = 3;

    // ============================================================
    // Clock and timing figures in nanoseconds, fast and slow grade
    // ============================================================
    localparam int CLK_PERIOD_NS               = 25;
    localparam int READ_CYCLE_MIN_FAST_NS      = 55;
    localparam int READ_CYCLE_MIN_SLOW_NS      = 70;
    localparam int ADDRESS_ACCESS_TIME_FAST_NS = 55;
    localparam int ADDRESS_ACCESS_TIME_SLOW_NS = 70;
    localparam int WRITE_CYCLE_MIN_FAST_NS     = 55;
    localparam int WRITE_CYCLE_MIN_SLOW_NS     = 70;
    localparam int ADDRESS_TO_WRITE_END_FAST_NS  = 45;
    localparam int ADDRESS_TO_WRITE_END_SLOW_NS  = 60;
    localparam int BYTE_SEL_TO_WRITE_END_FAST_NS = 50;
    localparam int BYTE_SEL_TO_WRITE_END_SLOW_NS = 60;
    localparam int WRITE_DATA_SETUP_FAST_NS    = 25;
    localparam int WRITE_DATA_SETUP_SLOW_NS    = 30;
    localparam int STROBE_WIDTH_FAST_NS        = 40;
    localparam int STROBE_WIDTH_SLOW_NS        = 50;

    // ============================================================
    // Helpers for turning least times into whole clock cycles
    // ============================================================
    function automatic int cycles_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // The strobe low window must cover every setup figure measured to write end.
    localparam int WR_PULSE_FAST_NS = max2(max2(STROBE_WIDTH_FAST_NS, WRITE_DATA_SETUP_FAST_NS),
        max2(ADDRESS_TO_WRITE_END_FAST_NS, BYTE_SEL_TO_WRITE_END_FAST_NS));
    localparam int WR_PULSE_SLOW_NS = max2(max2(STROBE_WIDTH_SLOW_NS, WRITE_DATA_SETUP_SLOW_NS),
        max2(ADDRESS_TO_WRITE_END_SLOW_NS, BYTE_SEL_TO_WRITE_END_SLOW_NS));
    localparam int RD_WAIT_FAST_NS  = max2(ADDRESS_ACCESS_TIME_FAST_NS, READ_CYCLE_MIN_FAST_NS);
    localparam int RD_WAIT_SLOW_NS  = max2(ADDRESS_ACCESS_TIME_SLOW_NS, READ_CYCLE_MIN_SLOW_NS);

    localparam logic [CNT_W-1:0] WR_PULSE_FAST_CNT = CNT_W'(cycles_min(WR_PULSE_FAST_NS));
    localparam logic [CNT_W-1:0] WR_PULSE_SLOW_CNT = CNT_W'(cycles_min(WR_PULSE_SLOW_NS));
    localparam logic [CNT_W-1:0] RD_WAIT_FAST_CNT  = CNT_W'(cycles_min(RD_WAIT_FAST_NS));
    localparam logic [CNT_W-1:0] RD_WAIT_SLOW_CNT  = CNT_W'(cycles_min(RD_WAIT_SLOW_NS));
    localparam logic [CNT_W-1:0] CNT_ONE           = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO          = CNT_W'(0);

    // ============================================================
    // Access sequencer states
    // ============================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_END,
        ST_RD_WAIT,
        ST_RD_END
    } state_t;

endpackage

//--- testbench/async_sram_128k_x16_access_tb_top.sv
module async_sram_128k_x16_access_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sram_host_pkg::*;

    logic              mclk = 1'b0;
    logic              rst_b;
    logic              grade_slow;
    logic              req_valid;
    logic              req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic [1:0]        req_bytes;
    logic              req_ready_q;
    logic              rsp_valid_q;
    logic [DATA_W-1:0] rsp_rdata_q;
    logic [ADDR_W-1:0] word_address_q;
    logic              chip_sel_n_q;
    logic              write_strobe_n_q;
    logic              out_drive_n_q;
    logic              upper_byte_sel_n_q;
    logic              lower_byte_sel_n_q;
    logic [DATA_W-1:0] data_bus_sample;
    logic [DATA_W-1:0] data_bus_value_q;
    logic              data_bus_en_q;
    logic [DATA_W-1:0] drive_value;
    logic [1:0]        lane_drive;
    logic [DATA_W-1:0] last_bus_q = '0;
    logic [DATA_W-1:0] ref_mem [int];
    logic [31:0]       lfsr_q;
    int                error_cnt;
    int                tests_run;
    int                sel_cnt = 0;
    int                stb_cnt = 0;

    sram_host u_dut (.mclk(mclk), .rst_b(rst_b), .grade_slow(grade_slow),
        .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_bytes(req_bytes), .req_ready_q(req_ready_q),
        .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .word_address_q(word_address_q),
        .chip_sel_n_q(chip_sel_n_q), .write_strobe_n_q(write_strobe_n_q),
        .out_drive_n_q(out_drive_n_q), .upper_byte_sel_n_q(upper_byte_sel_n_q),
        .lower_byte_sel_n_q(lower_byte_sel_n_q), .data_bus_sample(data_bus_sample),
        .data_bus_value_q(data_bus_value_q), .data_bus_en_q(data_bus_en_q));

    sram_array_model u_mem (.grade_slow(grade_slow), .word_address(word_address_q),
        .chip_sel_n(chip_sel_n_q), .write_strobe_n(write_strobe_n_q),
        .out_drive_n(out_drive_n_q), .upper_byte_sel_n(upper_byte_sel_n_q),
        .lower_byte_sel_n(lower_byte_sel_n_q), .data_bus(data_bus_sample),
        .drive_value(drive_value), .lane_drive(lane_drive));

    // ============================================================
    // Clock and wire resolution
    // ============================================================
    // Undriven lanes show the inverse of their last level, so a floating read never matches.
    always #12.5 mclk = ~mclk;
    assign data_bus_sample = data_bus_en_q ? data_bus_value_q :
        {lane_drive[1] ? drive_value[15:8] : ~last_bus_q[15:8],
         lane_drive[0] ? drive_value[7:0] : ~last_bus_q[7:0]};
    always @(posedge mclk) last_bus_q <= data_bus_sample;

    // ============================================================
    // Reporting
    // ============================================================
    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got,
                            input logic [15:0] mask);
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp & mask, got & mask);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    // A wait that runs out of its bound closes the run at once.
    task automatic wait_for(input string what, input bit for_rsp);
        int n;
        n = 0;
        while ((for_rsp ? rsp_valid_q : req_ready_q) !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        if ((for_rsp ? rsp_valid_q : req_ready_q) !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %s expected 1 seen timeout", what);
            give_verdict();
        end
    endtask

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // ============================================================
    // One request, checked against the reference word store
    // ============================================================
    task automatic access(input logic wr, input logic slow, input logic [16:0] a,
                          input logic [15:0] d, input logic [1:0] b);
        logic [15:0] mask;
        logic [15:0] exp;
        mask = {{8{b[1]}}, {8{b[0]}}};
        wait_for("ready", 1'b0);
        exp = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : '0;
        {req_valid, req_write, grade_slow, req_addr, req_wdata, req_bytes} = {1'b1, wr, slow, a, d, b};
        @(negedge mclk);
        req_valid = 1'b0;
        cmp_bit("select low", 1'b0, chip_sel_n_q);
        cmp_bit("upper select", !b[1], upper_byte_sel_n_q);
        cmp_bit("lower select", !b[0], lower_byte_sel_n_q);
        if (wr) ref_mem[int'(a)] = (exp & ~mask) | (d & mask);
        else begin
            wait_for("read answer", 1'b1);
            cmp_word("read data", exp, rsp_rdata_q, mask);
        end
    endtask

    // ============================================================
    // Pin monitors, sampled mid-cycle where the registers have settled
    // ============================================================
    // Strobe low time is counted to check every setup figure to write end, select low time to check the read wait.
    always @(negedge mclk) begin
        if (rst_b) begin
            cmp_bit("strobe high in read", 1'b1, write_strobe_n_q | out_drive_n_q);
            cmp_bit("no contention", 1'b0, data_bus_en_q & (|lane_drive));
            if (rsp_valid_q === 1'b1)
                cmp_bit("read wait", 1'b1, sel_cnt * 25 >= (grade_slow ? 70 : 55));
            if (write_strobe_n_q === 1'b1 && stb_cnt > 0)
                cmp_bit("write window", 1'b1, stb_cnt * 25 >= (grade_slow ? 60 : 50));
            sel_cnt = (chip_sel_n_q === 1'b0) ? sel_cnt + 1 : 0;
            stb_cnt = (write_strobe_n_q === 1'b0) ? stb_cnt + 1 : 0;
        end
    end

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        {rst_b, grade_slow, req_valid, req_write} = 4'b0000;
        {req_addr, req_wdata, req_bytes} = '0;
        {error_cnt, tests_run} = '0;
        lfsr_q = 32'h071F9F08;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        // Every lane code at the top address, read back whole and by lane.
        access(1'b1, 1'b0, 17'h1FFFF, 16'h1234, 2'b11);
        for (int i = 0; i < 4; i++) begin
            access(1'b1, i[0], 17'h1FFFF, 16'hA5C3 + 16'(i), i[1:0]);
            access(1'b0, i[1], 17'h1FFFF, 16'h0000, 2'b11);
            access(1'b0, i[0], 17'h1FFFF, 16'h0000, i[1:0]);
        end
        // Random mix over a small address set so reads hit earlier writes.
        for (int i = 0; i < 300; i++) begin
            lfsr_q = lfsr_step(lfsr_q);
            access(lfsr_q[0], lfsr_q[1], {lfsr_q[20] ? 13'h1FFF : 13'h0000, lfsr_q[5:2]},
                   lfsr_q[31:16], lfsr_q[7:6]);
        end
        give_verdict();
    end
endmodule

//--- testbench/sram_array_model.sv
module sram_array_model
(
    input  wire logic                             grade_slow,
    input  wire logic [sram_host_pkg::ADDR_W-1:0] word_address,
    input  wire logic                             chip_sel_n,
    input  wire logic                             write_strobe_n,
    input  wire logic                             out_drive_n,
    input  wire logic                             upper_byte_sel_n,
    input  wire logic                             lower_byte_sel_n,
    input  wire logic [sram_host_pkg::DATA_W-1:0] data_bus,
    output logic      [sram_host_pkg::DATA_W-1:0] drive_value,
    output logic      [1:0]                       lane_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    import sram_host_pkg::*;

    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] rd;
    time               addr_t = 0;
    time               ctl_t = 0;
    wire               write_act = !chip_sel_n && !write_strobe_n;

    // ============================================================
    // Write path
    // ============================================================
    // The word is stored when the overlap ends, whichever pin rises first.
    always @(negedge write_act) begin
        word = mem.exists(int'(word_address)) ? mem[int'(word_address)] : '0;
        if (!upper_byte_sel_n) word[15:8] = data_bus[15:8];
        if (!lower_byte_sel_n) word[7:0] = data_bus[7:0];
        mem[int'(word_address)] = word;
    end

    // ============================================================
    // Read path
    // ============================================================
    // Lanes release at once, so turn-off always beats turn-on.
    assign lane_drive[1] = !chip_sel_n && write_strobe_n && !out_drive_n
                           && !upper_byte_sel_n;
    assign lane_drive[0] = !chip_sel_n && write_strobe_n && !out_drive_n
                           && !lower_byte_sel_n;

    always @(word_address or chip_sel_n) addr_t = $time;
    always @(out_drive_n or upper_byte_sel_n or lower_byte_sel_n) ctl_t = $time;

    // Data is inverted garbage until every access time has run, so an early sample fails.
    // Old data stays on the lanes for the hold time after the address moves.
    always #1 begin
        if ($time - addr_t >= 10) begin
            rd = mem.exists(int'(word_address)) ? mem[int'(word_address)] : '0;
            drive_value = ($time - addr_t >= (grade_slow ? 70 : 55) &&
                           $time - ctl_t >= (grade_slow ? 35 : 25)) ? rd : ~rd;
        end
    end
endmodule
